//--- hdl/tws_defs.svh
// address map, field positions, reset values and clock codes of the serial block
`ifndef TWS_DEFS_SVH
`define TWS_DEFS_SVH
`define TWS_ADDR_MODE0     16'hff80
`define TWS_ADDR_CLKSEL0   16'hff81
`define TWS_ADDR_SHIFT0    16'hff82
`define TWS_ADDR_TXBUF0    16'hff84
`define TWS_ADDR_MODE1     16'hff88
`define TWS_ADDR_CLKSEL1   16'hff89
`define TWS_ADDR_SHIFT1    16'hff8a
`define TWS_ADDR_TXBUF1    16'hff8c
`define TWS_ADDR_PDIR0     16'hff20
`define TWS_ADDR_PDIR1     16'hff21
`define TWS_ADDR_PLAT0     16'hff00
`define TWS_ADDR_PLAT1     16'hff01
`define TWS_MODE_EN_BIT    7
`define TWS_MODE_TRMD_BIT  6
`define TWS_MODE_SSE_BIT   5
`define TWS_MODE_DIR_BIT   4
`define TWS_MODE_BUSY_BIT  0
`define TWS_CLK_CKP_BIT    4
`define TWS_MODE_RESET     8'h00
`define TWS_CLK_RESET      8'h00
`define TWS_PDIR_RESET     8'hff
`define TWS_PLAT_RESET     8'h00
`define TWS_CKS_EXT        3'h7
`define TWS_BITS_LAST      3'h7
`endif

//--- hdl/tws_pkg.sv
// types shared by the serial block modules
package tws_pkg;
   typedef enum logic [1:0] {
      TWS_ST_IDLE = 2'b00,
      TWS_ST_PEND = 2'b01,
      TWS_ST_BUSY = 2'b10
   } tws_state_t;
   typedef logic [7:0] tws_byte_t;
endpackage

//--- hdl/tws_chan_if.sv
// signals between the register file and one serial channel engine
`timescale 1ns/1ps
interface tws_chan_if;
   logic                  en;
   logic                  trmd;
   logic                  dir;
   logic [2:0]            cks;
   logic                  ssi_use;
   logic                  ssi;
   logic                  wr_tx;
   tws_pkg::tws_byte_t    tx_data;
   logic                  rd_rx;
   logic                  sck_in;
   logic                  si;
   logic                  busy;
   tws_pkg::tws_byte_t    shift;
   logic                  so;
   logic                  sck;
   logic                  done;
   modport regs (output en, trmd, dir, cks, ssi_use, ssi, wr_tx, tx_data, rd_rx,
                 output sck_in, si, input busy, shift, so, sck, done);
   modport chan (input en, trmd, dir, cks, ssi_use, ssi, wr_tx, tx_data, rd_rx,
                 input sck_in, si, output busy, shift, so, sck, done);
endinterface

//--- hdl/tws_chan.sv
// one eight-bit clocked serial channel: divider, shifter, hold and completion
`timescale 1ns/1ps
`include "tws_defs.svh"
module tws_chan (
   input  wire logic  ref_clk_in,   // system clock
   input  wire logic  rst_n_in,     // async reset, active low
   tws_chan_if.chan   c             // channel control and status
);
   import tws_pkg::*;
   tws_state_t  st_q;
   logic [6:0]  div_q;
   logic [2:0]  cnt_q;
   logic [7:0]  sh_q;
   logic        sck_q;
   logic        sck_prev_q;
   logic        done_q;
   logic        so_q;
   logic        master;
   logic        hold;
   logic [6:0]  mask;
   logic        tick;
   logic        rise;

   // master divides by 2^(k+1): sck toggles every 2^k cycles
   assign master = (c.cks != `TWS_CKS_EXT);
   assign mask   = 7'((8'h01 << c.cks) - 8'h01);
   assign tick   = (st_q == TWS_ST_BUSY) && ((div_q & mask) == mask);
   // [R19] select input holds
   assign hold   = c.ssi_use & c.ssi;
   // slave edges are ignored while the select input is in use and high, so a transfer suspends
   assign rise   = master ? (tick & ~sck_q)
                          : ((st_q == TWS_ST_BUSY) & ~hold & c.sck_in & ~sck_prev_q);

   // divider restarts with each transfer so the first half period is full length
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= 7'h00;
      end else if (st_q != TWS_ST_BUSY) begin
         div_q <= 7'h00;
      end else begin
         div_q <= div_q + 7'h01;
      end
   end

   // slave clock edge detect works on the already synchronised pin
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sck_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= c.sck_in;
      end
   end

   // output bit register: during a master transfer it moves only on the falling half, so the
   // pin never changes in the same cycle as the clock edge that the far side samples on
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         so_q <= 1'b0;
      end else if (!c.en) begin
         so_q <= 1'b0;
      end else if (st_q == TWS_ST_IDLE && c.wr_tx) begin
         so_q <= c.dir ? c.tx_data[0] : c.tx_data[7];
      end else if (st_q != TWS_ST_BUSY || !master || (tick && sck_q)) begin
         so_q <= c.dir ? sh_q[0] : sh_q[7];
      end
   end

   // transfer sequencing and shifting
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q   <= TWS_ST_IDLE;
         sh_q   <= 8'h00;
         cnt_q  <= 3'h0;
         sck_q  <= 1'b1;
         done_q <= 1'b0;
      end else if (!c.en) begin
         // [R7] disable clears channel
         st_q   <= TWS_ST_IDLE;
         sh_q   <= 8'h00;
         cnt_q  <= 3'h0;
         sck_q  <= 1'b1;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            TWS_ST_IDLE: begin
               // [R13] write starts transfer
               if (c.wr_tx) begin
                  sh_q <= c.tx_data;
               end
               // [R14] read starts reception
               if (c.wr_tx || c.rd_rx) begin
                  st_q  <= hold ? TWS_ST_PEND : TWS_ST_BUSY;
                  cnt_q <= 3'h0;
               end
            end
            TWS_ST_PEND: begin
               if (!hold) begin
                  st_q <= TWS_ST_BUSY;
               end
            end
            TWS_ST_BUSY: begin
               if (master && tick) begin
                  sck_q <= ~sck_q;
               end
               // [R22] bit order shift
               if (rise) begin
                  sh_q  <= c.dir ? {c.si, sh_q[7:1]} : {sh_q[6:0], c.si};
                  cnt_q <= cnt_q + 3'h1;
                  // [R18] eight bits done
                  if (cnt_q == `TWS_BITS_LAST) begin
                     st_q   <= TWS_ST_IDLE;
                     done_q <= 1'b1;
                  end
               end
            end
            default: begin
               st_q <= TWS_ST_IDLE;
            end
         endcase
      end
   end

   assign c.busy  = (st_q == TWS_ST_BUSY);
   assign c.shift = sh_q;
   assign c.sck   = sck_q;
   assign c.done  = done_q;
   // [R21] receive only output low
   assign c.so    = c.trmd & so_q;

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence last_bit_s;
      st_q == TWS_ST_BUSY && cnt_q == 3'h7 && rise;
   endsequence
   done_after_a: assert property (c.done |-> $past(cnt_q) == 3'h7 && $past(rise)) // [R18]
      else $error("done without eighth bit");
   last_bit_a: assert property (c.en ##0 last_bit_s |=> c.done && st_q == TWS_ST_IDLE) // [R18]
      else $error("eighth bit did not finish transfer");
   disable_clr_a: assert property (!c.en |=> st_q == TWS_ST_IDLE && sh_q == 8'h00) // [R7]
      else $error("disable did not clear channel");
   start_load_a: assert property (c.en && st_q == TWS_ST_IDLE && c.wr_tx && !hold // [R13]
      |=> c.busy && sh_q == $past(c.tx_data))
      else $error("write did not start transfer");
   hold_pend_a: assert property (c.en && st_q == TWS_ST_PEND && hold |=> !c.busy) // [R19]
      else $error("held transfer started");
   rx_low_a: assert property (!c.trmd |-> !c.so) // [R21]
      else $error("output not low in receive mode");
endmodule // tws_chan

//--- hdl/tws_top.sv
// register file, port pins and two serial channels of the three-wire block
`timescale 1ns/1ps
`include "tws_defs.svh"
// Function
// [R1] reset sets both port direction registers to all ones
// [R2] direction bit 0 drives its pin, 1 leaves it as input
// [R3] software sets clock pin direction 0 and latch 1 for clock output
// [R4] software clears direction bit and latch for data output pin
// [R5] software sets direction 1 for clock, data and select inputs
// [R6] channel enable low stops serial use; pins act as port pins
// [R7] clearing enable clears in-progress flag and shift register
// [R8] reset clears both mode registers to zero
// [R9] first mode register: enable, mode, direction, read-only busy; others zero
// [R10] second mode register adds slave-select use bit at bit 5
// [R11] link uses serial clock, serial output and serial input lines
// [R12] software sets clock select, mode bits, enable, then starts transfer
// [R13] enabled channel starts full-duplex transfer on transmit buffer write
// [R14] enabled channel starts reception on shift register read
// [R15] slave needs clock code all ones and clock pin as input
// [R16] software clears clock polarity to use clock pin as port
// [R17] clock select holds polarity at bit 4, source at bits 2..0
// [R18] busy set on start; after eight bits cleared and completion flagged
// [R19] high select input holds and suspends second channel slave transfers
// [R20] codes 0..6 divide clock by 2..128; code 7 is external clock
// [R21] receive-only mode holds serial output low
// [R22] eight-bit shift, MSB first for direction 0, LSB first for 1
module tws_top (
   input  wire logic        ref_clk_in,     // 10 MHz system clock
   input  wire logic        rst_n_in,       // async reset, active low
   input  wire logic [15:0] cpu_addr_in,    // register address
   input  wire logic [7:0]  cpu_wdata_in,   // write data
   input  wire logic        cpu_wr_in,      // write strobe, one cycle
   input  wire logic        cpu_rd_in,      // read strobe, one cycle
   output logic [7:0]       cpu_rdata_out,  // read data, one cycle after strobe
   input  wire logic [7:0]  port0_in,       // port 0 pin levels
   output logic [7:0]       port0_out,      // port 0 pin drive values
   output logic [7:0]       port0_oe_n_out, // port 0 enables, low drives
   input  wire logic [7:0]  port1_in,       // port 1 pin levels
   output logic [7:0]       port1_out,      // port 1 pin drive values
   output logic [7:0]       port1_oe_n_out, // port 1 enables, low drives
   output logic [1:0]       done_out        // completion flag pulses per channel
);
   import tws_pkg::*;
   logic [7:0] mode_q [2];
   logic [7:0] clk_q [2];
   logic [7:0] txb_q [2];
   logic [7:0] pdir0_q;
   logic [7:0] pdir1_q;
   logic [7:0] plat0_q;
   logic [7:0] plat1_q;
   logic [7:0] p0_s1_q;
   logic [7:0] p0_s2_q;
   logic [7:0] p1_s1_q;
   logic [7:0] p1_s2_q;
   logic [7:0] rdata_d;
   logic [7:0] p0_d;
   logic [7:0] p1_d;
   logic [7:0] mode_rd [2];
   logic [1:0] master;
   logic       wr_mode [2];
   logic       wr_clk [2];
   logic       wr_txb [2];
   logic       rd_sh [2];

   tws_chan_if cif [2] ();

   // pins come from outside the clock domain: two flops before any use
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         p0_s1_q <= 8'h00;
         p0_s2_q <= 8'h00;
         p1_s1_q <= 8'h00;
         p1_s2_q <= 8'h00;
      end else begin
         p0_s1_q <= port0_in;
         p0_s2_q <= p0_s1_q;
         p1_s1_q <= port1_in;
         p1_s2_q <= p1_s1_q;
      end
   end

   // per-channel register decode and channel engines
   for (genvar g = 0; g < 2; g++) begin : g_ch
      localparam logic [15:0] A_MODE = (g == 0) ? `TWS_ADDR_MODE0 : `TWS_ADDR_MODE1;
      localparam logic [15:0] A_CLK  = (g == 0) ? `TWS_ADDR_CLKSEL0 : `TWS_ADDR_CLKSEL1;
      localparam logic [15:0] A_SH   = (g == 0) ? `TWS_ADDR_SHIFT0 : `TWS_ADDR_SHIFT1;
      localparam logic [15:0] A_TXB  = (g == 0) ? `TWS_ADDR_TXBUF0 : `TWS_ADDR_TXBUF1;
      assign wr_mode[g] = cpu_wr_in && (cpu_addr_in == A_MODE);
      assign wr_clk[g]  = cpu_wr_in && (cpu_addr_in == A_CLK);
      assign wr_txb[g]  = cpu_wr_in && (cpu_addr_in == A_TXB);
      assign rd_sh[g]   = cpu_rd_in && (cpu_addr_in == A_SH);

      // [R8] mode reset zero
      always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            mode_q[g] <= `TWS_MODE_RESET;
            clk_q[g]  <= `TWS_CLK_RESET;
            txb_q[g]  <= 8'h00;
         end else begin
            // [R10] select bit only on second
            if (wr_mode[g]) begin
               mode_q[g] <= cpu_wdata_in & ((g == 1) ? 8'hf0 : 8'hd0);
            end
            // [R17] polarity and source fields
            if (wr_clk[g]) begin
               clk_q[g] <= cpu_wdata_in & 8'h17;
            end
            if (wr_txb[g]) begin
               txb_q[g] <= cpu_wdata_in;
            end
         end
      end

      // [R9] busy flag in bit 0
      assign mode_rd[g] = {mode_q[g][7:4], 3'h0, cif[g].busy};
      // [R20] code 7 selects slave
      assign master[g]  = (clk_q[g][2:0] != `TWS_CKS_EXT);

      // [R6] channel runs only when enabled
      assign cif[g].en      = mode_q[g][`TWS_MODE_EN_BIT];
      assign cif[g].trmd    = mode_q[g][`TWS_MODE_TRMD_BIT];
      assign cif[g].dir     = mode_q[g][`TWS_MODE_DIR_BIT];
      assign cif[g].cks     = clk_q[g][2:0];
      // [R19] select gating second slave
      assign cif[g].ssi_use = (g == 1) && mode_q[g][`TWS_MODE_SSE_BIT] && !master[g];
      assign cif[g].wr_tx   = wr_txb[g];
      assign cif[g].tx_data = cpu_wdata_in;
      assign cif[g].rd_rx   = rd_sh[g];

      tws_chan u_chan (
         .ref_clk_in (ref_clk_in),
         .rst_n_in   (rst_n_in),
         .c          (cif[g])
      );
   end

   // [R11] clock, output, input pins
   // polarity bit flips the external clock so the engine always sees the same phase
   assign cif[0].sck_in = p1_s2_q[0] ^ clk_q[0][`TWS_CLK_CKP_BIT];
   assign cif[0].si     = p1_s2_q[1];
   assign cif[0].ssi    = 1'b0;
   assign cif[1].sck_in = p0_s2_q[4] ^ clk_q[1][`TWS_CLK_CKP_BIT];
   assign cif[1].si     = p0_s2_q[3];
   assign cif[1].ssi    = p0_s2_q[5];

   // port direction and output latch registers
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         // [R1] directions reset to inputs
         pdir0_q <= `TWS_PDIR_RESET;
         pdir1_q <= `TWS_PDIR_RESET;
         plat0_q <= `TWS_PLAT_RESET;
         plat1_q <= `TWS_PLAT_RESET;
      end else if (cpu_wr_in) begin
         case (cpu_addr_in)
            `TWS_ADDR_PDIR0: pdir0_q <= cpu_wdata_in;
            `TWS_ADDR_PDIR1: pdir1_q <= cpu_wdata_in;
            `TWS_ADDR_PLAT0: plat0_q <= cpu_wdata_in;
            `TWS_ADDR_PLAT1: plat1_q <= cpu_wdata_in;
            default: begin
            end
         endcase
      end
   end

   // pin values: latch unless an enabled channel owns the pin
   always_comb begin
      p0_d = plat0_q;
      p1_d = plat1_q;
      // [R6] stopped pins are ports
      if (cif[0].en) begin
         p1_d[2] = cif[0].so;
         if (master[0]) begin
            p1_d[0] = cif[0].sck ^ clk_q[0][`TWS_CLK_CKP_BIT];
         end
      end
      if (cif[1].en) begin
         p0_d[2] = cif[1].so;
         if (master[1]) begin
            p0_d[4] = cif[1].sck ^ clk_q[1][`TWS_CLK_CKP_BIT];
         end
      end
   end

   // pins are registered so the outputs never glitch on mode writes
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port0_out      <= `TWS_PLAT_RESET;
         port1_out      <= `TWS_PLAT_RESET;
         port0_oe_n_out <= `TWS_PDIR_RESET;
         port1_oe_n_out <= `TWS_PDIR_RESET;
      end else begin
         port0_out      <= p0_d;
         port1_out      <= p1_d;
         // [R2] direction bit gates driver
         port0_oe_n_out <= pdir0_q;
         port1_oe_n_out <= pdir1_q;
      end
   end

   // read mux; unmapped addresses read zero, port latches read pin level on inputs
   always_comb begin
      case (cpu_addr_in)
         `TWS_ADDR_MODE0:   rdata_d = mode_rd[0];
         `TWS_ADDR_CLKSEL0: rdata_d = clk_q[0];
         `TWS_ADDR_SHIFT0:  rdata_d = cif[0].shift;
         `TWS_ADDR_TXBUF0:  rdata_d = txb_q[0];
         `TWS_ADDR_MODE1:   rdata_d = mode_rd[1];
         `TWS_ADDR_CLKSEL1: rdata_d = clk_q[1];
         `TWS_ADDR_SHIFT1:  rdata_d = cif[1].shift;
         `TWS_ADDR_TXBUF1:  rdata_d = txb_q[1];
         `TWS_ADDR_PDIR0:   rdata_d = pdir0_q;
         `TWS_ADDR_PDIR1:   rdata_d = pdir1_q;
         `TWS_ADDR_PLAT0:   rdata_d = (pdir0_q & p0_s2_q) | (~pdir0_q & plat0_q);
         `TWS_ADDR_PLAT1:   rdata_d = (pdir1_q & p1_s2_q) | (~pdir1_q & plat1_q);
         default:           rdata_d = 8'h00;
      endcase
   end

   // read data and completion pulses leave from flops
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cpu_rdata_out <= 8'h00;
         done_out      <= 2'b00;
      end else begin
         if (cpu_rd_in) begin
            cpu_rdata_out <= rdata_d;
         end
         // [R18] completion flag raised
         done_out <= {cif[1].done, cif[0].done};
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   oe_follow_a: assert property (cpu_wr_in && cpu_addr_in == `TWS_ADDR_PDIR0 // [R2]
      |=> ##1 port0_oe_n_out == $past(cpu_wdata_in, 2))
      else $error("port 0 enable did not follow direction");
   busy_read_a: assert property (cpu_rd_in && cpu_addr_in == `TWS_ADDR_MODE0 // [R9]
      |=> cpu_rdata_out[0] == $past(cif[0].busy) && cpu_rdata_out[3:1] == 3'h0)
      else $error("mode read busy bit wrong");
   sck_drive_a: assert property (cif[0].en && master[0] // [R20]
      |=> port1_out[0] == $past(cif[0].sck ^ clk_q[0][4]))
      else $error("master clock not on pin");
   done_flag_a: assert property (cif[0].done |=> done_out[0]) // [R18]
      else $error("completion flag missing");
endmodule // tws_top

//--- verif/tws_peer.sv
// serial peripheral model that answers the first channel as its slave
`timescale 1ns/1ps
module tws_peer (
   input  wire logic       rst_n_in,  // clears the bit counters, active low
   input  wire logic       sck_in,    // serial clock seen on the wire
   input  wire logic       so_in,     // serial data from the block
   input  wire logic [7:0] pat_in,    // byte handed back to the block
   output logic            si_out     // serial data to the block
);
   logic [7:0] cap_q;
   int         rx_n;
   int         tx_n;
   logic [7:0] got_q [$];  // whole frames only, partial ones are dropped at reset

   initial si_out = 1'b0;

   // clock line: sample the serial output on the rising clock
   always @(posedge sck_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_n = 0;
      end else begin
         cap_q = {cap_q[6:0], so_in};
         rx_n  = rx_n + 1;
         if (rx_n == 8) begin
            got_q.push_back(cap_q);
            rx_n = 0;
            // hold time over: show the inverse so a stale level cannot pass
            si_out <= ~si_out;
         end
      end
   end

   // input line: next bit of the pattern on each falling clock
   always @(negedge sck_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_n   = 0;
         si_out = ~si_out;
      end else begin
         si_out = pat_in[7 - tx_n];
         tx_n   = (tx_n + 1) % 8;
      end
   end
endmodule // tws_peer

//--- verif/tb.sv
// self-checking bench for the three-wire serial block
`timescale 1ns/1ps
module tb;
   import tws_pkg::*;
   logic        ref_clk_in = 1'b0;
   logic        rst_n_in;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic [7:0]  p0_in, p0_out, p0_oe_n, p1_in, p1_out, p1_oe_n;
   logic [1:0]  done;
   logic [7:0]  ext0, ext1;
   logic        peer_si, peer_rst_n, prev_sck;
   tws_byte_t   pat;
   int          bad_count, total_checks, cyc, falls, last_fall, half;
   int          done_n [2];
   wire         sck_w = p1_oe_n[0] ? 1'b1 : p1_out[0];  // pull-up assumed on the clock line

   // wire levels: the block wins where it drives, the far side elsewhere
   assign p1_in = (~p1_oe_n & p1_out) | (p1_oe_n & {ext1[7:2], peer_si, ext1[0]});
   assign p0_in = (~p0_oe_n & p0_out) | (p0_oe_n & ext0);

   always #50 ref_clk_in = ~ref_clk_in;

   tws_top i_dut (
      .ref_clk_in     (ref_clk_in),
      .rst_n_in       (rst_n_in),
      .cpu_addr_in    (addr),
      .cpu_wdata_in   (wdata),
      .cpu_wr_in      (wr),
      .cpu_rd_in      (rd),
      .cpu_rdata_out  (rdata),
      .port0_in       (p0_in),
      .port0_out      (p0_out),
      .port0_oe_n_out (p0_oe_n),
      .port1_in       (p1_in),
      .port1_out      (p1_out),
      .port1_oe_n_out (p1_oe_n),
      .done_out       (done)
   );

   tws_peer i_peer (
      .rst_n_in (peer_rst_n),
      .sck_in   (sck_w),
      .so_in    (p1_out[2]),
      .pat_in   (pat),
      .si_out   (peer_si)
   );

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // cycle count, clock fall spacing, done pulses and the hang limit
   always @(posedge ref_clk_in) begin
      cyc = cyc + 1;
      if (prev_sck === 1'b1 && sck_w === 1'b0) begin
         falls     = falls + 1;
         half      = cyc - last_fall;
         last_fall = cyc;
      end
      prev_sck = sck_w;
      if (done[0] === 1'b1) done_n[0] = done_n[0] + 1;
      if (done[1] === 1'b1) done_n[1] = done_n[1] + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         stop_test();
      end
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_n(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one-cycle strobes launched on the falling edge
   task automatic wr8(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk_in);
      addr  = a;
      wdata = d;
      wr    = 1'b1;
      @(negedge ref_clk_in);
      wr = 1'b0;
   endtask

   task automatic rd8(input logic [15:0] a, output logic [7:0] d);
      @(negedge ref_clk_in);
      addr = a;
      rd   = 1'b1;
      @(negedge ref_clk_in);
      rd = 1'b0;
      @(negedge ref_clk_in);
      d = rdata;
   endtask

   task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd8(a, v);
      chk8(v, exp);
   endtask

   // bounded wait for completion, then exactly one pulse must have shown
   task automatic wait_done(input int ch, input int n0);
      int i;
      for (i = 0; i < 3000 && done_n[ch] == n0; i++) @(negedge ref_clk_in);
      repeat (4) @(negedge ref_clk_in);
      chk_n(done_n[ch] - n0, 1);
   endtask

   task automatic peer_clear;
      @(negedge ref_clk_in);
      peer_rst_n = 1'b0;
      @(negedge ref_clk_in);
      peer_rst_n = 1'b1;
      i_peer.got_q.delete();
   endtask

   function automatic logic [7:0] rev8(input logic [7:0] x);
      int i;
      for (i = 0; i < 8; i++) rev8[i] = x[7 - i];
   endfunction

   initial begin
      logic [7:0] v, d;
      logic       dir;
      int         k, n0, i;
      rst_n_in = 1'b0; addr = 16'h0000; wdata = 8'h00; wr = 1'b0; rd = 1'b0;
      ext0 = 8'h30; ext1 = 8'h00; pat = 8'h00; peer_rst_n = 1'b0; prev_sck = 1'b1;
      bad_count = 0; total_checks = 0; cyc = 0; falls = 0; last_fall = 0; half = 0;
      done_n[0] = 0; done_n[1] = 0;
      k = $urandom(32'h18654c89);
      repeat (5) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      rst_n_in = 1'b1; peer_rst_n = 1'b1;
      // reset values and register layout
      chk8(p1_oe_n, 8'hff);
      rdchk(16'hff20, 8'hff);
      rdchk(16'hff21, 8'hff);
      rdchk(16'hff80, 8'h00);
      rdchk(16'hff88, 8'h00);
      rdchk(16'hff90, 8'h00);
      wr8(16'hff80, 8'hff);
      rdchk(16'hff80, 8'hd0);
      wr8(16'hff80, 8'h00);
      wr8(16'hff88, 8'hff);
      rdchk(16'hff88, 8'hf0);
      wr8(16'hff88, 8'h00);
      wr8(16'hff81, 8'hff);
      rdchk(16'hff81, 8'h17);
      wr8(16'hff89, 8'hff);
      rdchk(16'hff89, 8'h17);
      wr8(16'hff81, 8'h00);
      wr8(16'hff89, 8'h00);
      // stopped channels leave the pins as plain ports
      for (i = 0; i < 4; i++) begin
         d = 8'($urandom);
         v = 8'($urandom);
         ext0 = 8'($urandom);
         wr8(16'hff20, d);
         wr8(16'hff00, v);
         repeat (2) @(negedge ref_clk_in);
         chk8(p0_oe_n, d);
         chk8(p0_out & ~d, v & ~d);
         rdchk(16'hff20, d);
         rdchk(16'hff00, (d & ext0) | (~d & v));
      end
      // first channel as master, every divider code, random bit order
      wr8(16'hff21, 8'hfa);
      wr8(16'hff01, 8'h01);
      for (k = 0; k < 7; k++) begin
         d = 8'($urandom);
         pat = 8'($urandom);
         v = 8'($urandom);
         dir = v[0];
         wr8(16'hff80, 8'h00);
         wr8(16'hff81, k[7:0]);
         wr8(16'hff80, {3'b110, dir, 4'h0});
         peer_clear();
         falls = 0;
         n0 = done_n[0];
         wr8(16'hff84, d);
         if (k > 3) rdchk(16'hff80, {3'b110, dir, 4'h1});
         wait_done(0, n0);
         rdchk(16'hff80, {3'b110, dir, 4'h0});
         chk_n(falls, 8);
         chk_n(half, 2 << k);
         chk_n(i_peer.got_q.size(), 1);
         if (i_peer.got_q.size() > 0) chk8(i_peer.got_q.pop_front(), dir ? rev8(d) : d);
         if (k >= 2) begin
            n0 = done_n[0];
            rd8(16'hff82, v);
            chk8(v, dir ? rev8(pat) : pat);
            wait_done(0, n0);
         end
      end
      // receive only: output held low, a read starts the next reception
      wr8(16'hff80, 8'h00);
      wr8(16'hff81, 8'h03);
      wr8(16'hff80, 8'h80);
      peer_clear();
      pat = 8'($urandom);
      n0 = done_n[0];
      rd8(16'hff82, v);
      wait_done(0, n0);
      chk_n(i_peer.got_q.size(), 1);
      if (i_peer.got_q.size() > 0) chk8(i_peer.got_q.pop_front(), 8'h00);
      n0 = done_n[0];
      rd8(16'hff82, v);
      chk8(v, pat);
      wait_done(0, n0);
      // abort in mid-frame by clearing the enable bit
      wr8(16'hff80, 8'h00);
      wr8(16'hff81, 8'h05);
      wr8(16'hff80, 8'hc0);
      n0 = done_n[0];
      wr8(16'hff84, 8'($urandom));
      repeat (300) @(negedge ref_clk_in);
      wr8(16'hff80, 8'h00);
      rdchk(16'hff80, 8'h00);
      rdchk(16'hff82, 8'h00);
      repeat (800) @(negedge ref_clk_in);
      chk_n(done_n[0] - n0, 0);
      // second channel as slave behind its select input
      // select pin high and clock pin idle high before the channel is set up
      ext0 = 8'h30;
      wr8(16'hff20, 8'hfb);
      wr8(16'hff89, 8'h07);
      wr8(16'hff88, 8'he0);
      pat = 8'($urandom);
      d = 8'($urandom);
      n0 = done_n[1];
      wr8(16'hff8c, d);
      repeat (20) @(negedge ref_clk_in);
      rdchk(16'hff88, 8'he0);
      chk_n(done_n[1] - n0, 0);
      ext0[5] = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      for (i = 7; i >= 0; i--) begin
         ext0[4] = 1'b0;
         ext0[3] = pat[i];
         repeat (4) @(negedge ref_clk_in);
         v[i] = p0_out[2];
         ext0[4] = 1'b1;
         repeat (4) @(negedge ref_clk_in);
      end
      wait_done(1, n0);
      chk8(v, d);
      rd8(16'hff8a, v);
      chk8(v, pat);
      wr8(16'hff88, 8'h00);
      stop_test();
   end
endmodule // tb
